// ==== src/pressure_threshold_irq_cfg.sv ====
// Purpose: pressure threshold interrupt configuration with Avalon-MM registers
// Assumes: single clock clk_i at 25 MHz, compare results arrive as levels
// Notes: waitrequest drops one cycle after a request; the access completes there
//
// The address map and the Avalon-MM interface to the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module pressure_threshold_irq_cfg
  import pth_irq_pkg::*;
(
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic [pth_irq_pkg::ADDR_W-1:0] address_i,
  input wire logic read_i,
  input wire logic write_i,
  input wire logic [pth_irq_pkg::BE_W-1:0] byteenable_i,
  input wire logic [pth_irq_pkg::DATA_W-1:0] writedata_i,
  output logic [pth_irq_pkg::DATA_W-1:0] readdata_o,
  output logic waitrequest_o,
  input wire logic pressure_high_i,
  input wire logic pressure_low_i,
  output logic baseline_capture_enable_o,
  output logic baseline_capture_reset_o,
  output logic threshold_irq_o,
  output logic irq_o
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [CFG_W-1:0] merge_low_byte(
    input logic [CFG_W-1:0] old_val,
    input logic [DATA_W-1:0] wdata,
    input logic lane_en,
    input logic [CFG_W-1:0] wmask
  );
    logic [CFG_W-1:0] res;
    res = old_val;
    if (lane_en)
    begin
      res = (old_val & ~wmask) | (wdata[CFG_W-1:0] & wmask);
    end
    return res;
  endfunction : merge_low_byte

  function automatic logic hit(
    input logic [ADDR_W-1:0] addr,
    input logic [ADDR_W-1:0] offs
  );
    return addr == offs;
  endfunction : hit

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic wait_ff;
  logic nxt_wait;
  logic [DATA_W-1:0] rdata_ff;
  logic [DATA_W-1:0] nxt_rdata;
  logic [CFG_W-1:0] cfg_ff;
  logic [CFG_W-1:0] nxt_cfg;
  logic base_rst_ff;
  logic nxt_base_rst;
  logic [EVT_W-1:0] status_ff;
  logic [EVT_W-1:0] nxt_status;
  logic [EVT_W-1:0] enable_ff;
  logic [EVT_W-1:0] nxt_enable;
  logic [EVT_W-1:0] src_prev_ff;
  logic thr_irq_ff;
  logic nxt_thr_irq;
  logic irq_ff;
  logic nxt_irq;
  logic req;
  logic wr_go;
  logic rd_go;
  logic src_rd_clr;
  logic [EVT_W-1:0] src;
  logic [EVT_W-1:0] evt_rise;
  logic [EVT_W-1:0] clr_bits;
  logic [SRC_W-1:0] src_view;

  // ----------------------------------------------------------------
  // bus handshake
  // ----------------------------------------------------------------
  // a request is taken once; waitrequest goes low in the next cycle
  // and the access completes at the edge that samples it low
  assign req = read_i | write_i;
  assign wr_go = write_i & ~wait_ff;
  assign rd_go = read_i & ~wait_ff;
  assign src_rd_clr = rd_go & hit(address_i, SOURCE_OFFS) & cfg_ff[LATCH_BIT];

  always_comb
  begin
    src_view = {|src, src};
    nxt_wait = 1'b1;
    nxt_rdata = rdata_ff;
    if (req && wait_ff)
    begin
      nxt_wait = 1'b0;
      nxt_rdata = RDATA_ZERO;
      if (read_i)
      begin
        if (hit(address_i, CFG_OFFS))
        begin
          nxt_rdata[CFG_W-1:0] = cfg_ff;
        end
        else if (hit(address_i, SOURCE_OFFS))
        begin
          nxt_rdata[SRC_W-1:0] = src_view;
        end
        else if (hit(address_i, STATUS_OFFS))
        begin
          nxt_rdata[EVT_W-1:0] = status_ff;
        end
        else if (hit(address_i, ENABLE_OFFS))
        begin
          nxt_rdata[EVT_W-1:0] = enable_ff;
        end
        else
        begin
          nxt_rdata = RDATA_ZERO;
        end
      end
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      wait_ff <= 1'b1;
      rdata_ff <= RDATA_ZERO;
    end
    else
    begin
      wait_ff <= nxt_wait;
      rdata_ff <= nxt_rdata;
    end
  end

  // ----------------------------------------------------------------
  // configuration register
  // ----------------------------------------------------------------
  always_comb
  begin
    nxt_cfg = cfg_ff;
    if (wr_go && hit(address_i, CFG_OFFS))
    begin
      nxt_cfg = merge_low_byte(cfg_ff, writedata_i, byteenable_i[0], CFG_WMASK);
    end
    nxt_cfg[BASE_RST_BIT] = 1'b0;
  end

  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      cfg_ff <= CFG_RST;
    end
    else
    begin
      cfg_ff <= nxt_cfg;
    end
  end

  // ----------------------------------------------------------------
  // baseline reset pulse
  // ----------------------------------------------------------------
  // the reset bit is never stored; a write of one gives a single pulse
  always_comb
  begin
    nxt_base_rst = 1'b0;
    if (wr_go && hit(address_i, CFG_OFFS) && byteenable_i[0])
    begin
      nxt_base_rst = writedata_i[BASE_RST_BIT];
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      base_rst_ff <= 1'b0;
    end
    else
    begin
      base_rst_ff <= nxt_base_rst;
    end
  end

  // ----------------------------------------------------------------
  // threshold request sources
  // ----------------------------------------------------------------
  threshold_source u_source (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .global_en_i(cfg_ff[GLOBAL_EN_BIT]),
    .high_en_i(cfg_ff[HIGH_EN_BIT]),
    .low_en_i(cfg_ff[LOW_EN_BIT]),
    .latch_i(cfg_ff[LATCH_BIT]),
    .read_clr_i(src_rd_clr),
    .pressure_high_i(pressure_high_i),
    .pressure_low_i(pressure_low_i),
    .src_o(src)
  );

  // ----------------------------------------------------------------
  // interrupt enable register
  // ----------------------------------------------------------------
  // only the low byte lane carries the mask
  always_comb
  begin
    nxt_enable = enable_ff;
    if (wr_go && hit(address_i, ENABLE_OFFS) && byteenable_i[0])
    begin
      nxt_enable = writedata_i[EVT_W-1:0];
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      enable_ff <= EVT_RST;
    end
    else
    begin
      enable_ff <= nxt_enable;
    end
  end

  // ----------------------------------------------------------------
  // sticky status and clear
  // ----------------------------------------------------------------
  // a rising source bit wins over a clear in the same cycle
  always_comb
  begin
    evt_rise = src & ~src_prev_ff;
    clr_bits = EVT_RST;
    if (wr_go && hit(address_i, CLEAR_OFFS) && byteenable_i[0])
    begin
      clr_bits = writedata_i[EVT_W-1:0];
    end
    nxt_status = (status_ff & ~clr_bits) | evt_rise;
  end

  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      status_ff <= EVT_RST;
      src_prev_ff <= EVT_RST;
    end
    else
    begin
      status_ff <= nxt_status;
      src_prev_ff <= src;
    end
  end

  // ----------------------------------------------------------------
  // interrupt outputs
  // ----------------------------------------------------------------
  // irq follows the next status so it moves with the status bit
  always_comb
  begin
    nxt_irq = |(nxt_status & nxt_enable);
    nxt_thr_irq = cfg_ff[GLOBAL_EN_BIT] & (|src);
  end

  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      irq_ff <= 1'b0;
      thr_irq_ff <= 1'b0;
    end
    else
    begin
      irq_ff <= nxt_irq;
      thr_irq_ff <= nxt_thr_irq;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign readdata_o = rdata_ff;
  assign waitrequest_o = wait_ff;
  assign baseline_capture_enable_o = cfg_ff[BASE_EN_BIT];
  assign baseline_capture_reset_o = base_rst_ff;
  assign threshold_irq_o = thr_irq_ff;
  assign irq_o = irq_ff;

endmodule : pressure_threshold_irq_cfg
`default_nettype wire

// ==== pkg/pth_irq_pkg.sv ====
// Purpose: constants for the pressure threshold interrupt configuration block
// Assumes: Avalon-MM slave, 32-bit data, byte addresses, one aligned word per register
// Notes: register fields sit in the low byte, upper bits read as zero
package pth_irq_pkg;

  // ----------------------------------------------------------------
  // bus and event field widths
  // ----------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int BE_W = 4;
  localparam int EVT_W = 2;

  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] CFG_OFFS = 8'h00;
  localparam logic [ADDR_W-1:0] SOURCE_OFFS = 8'h24;
  localparam logic [ADDR_W-1:0] STATUS_OFFS = 8'h28;
  localparam logic [ADDR_W-1:0] CLEAR_OFFS = 8'h2C;
  localparam logic [ADDR_W-1:0] ENABLE_OFFS = 8'h30;

  // ----------------------------------------------------------------
  // configuration register fields
  // ----------------------------------------------------------------
  localparam int HIGH_EN_BIT = 0;
  localparam int LOW_EN_BIT = 1;
  localparam int LATCH_BIT = 2;
  localparam int GLOBAL_EN_BIT = 3;
  localparam int BASE_RST_BIT = 4;
  localparam int BASE_EN_BIT = 5;
  localparam int CFG_W = 6;
  localparam logic [CFG_W-1:0] CFG_RST = 6'h00;
  localparam logic [CFG_W-1:0] CFG_WMASK = 6'h3F;

  // ----------------------------------------------------------------
  // source, status, clear and enable fields
  // ----------------------------------------------------------------
  localparam int EVT_HIGH_BIT = 0;
  localparam int EVT_LOW_BIT = 1;
  localparam int SRC_ACTIVE_BIT = 2;
  localparam int SRC_W = 3;
  localparam logic [EVT_W-1:0] EVT_RST = 2'h0;
  localparam logic [SRC_W-1:0] SRC_RST = 3'h0;

  // ----------------------------------------------------------------
  // bus answer values
  // ----------------------------------------------------------------
  localparam logic [DATA_W-1:0] RDATA_ZERO = 32'h0000_0000;

endpackage : pth_irq_pkg

// ==== src/threshold_source.sv ====
// Purpose: threshold event request bits, latched or following the condition
// Assumes: compare levels synchronous to clk_i
// Notes: a set in the clearing cycle wins over the clear
`timescale 1ns/1ps
`default_nettype none
module threshold_source
  import pth_irq_pkg::*;
(
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic global_en_i,
  input wire logic high_en_i,
  input wire logic low_en_i,
  input wire logic latch_i,
  input wire logic read_clr_i,
  input wire logic pressure_high_i,
  input wire logic pressure_low_i,
  output logic [pth_irq_pkg::EVT_W-1:0] src_o
);

  logic [EVT_W-1:0] src_ff;
  logic [EVT_W-1:0] nxt_src;
  logic [EVT_W-1:0] cond;

  // ----------------------------------------------------------------
  // request bits
  // ----------------------------------------------------------------
  always_comb
  begin
    cond = EVT_RST;
    cond[EVT_HIGH_BIT] = global_en_i & high_en_i & pressure_high_i;
    cond[EVT_LOW_BIT] = global_en_i & low_en_i & pressure_low_i;
    if (latch_i)
    begin
      nxt_src = (read_clr_i ? EVT_RST : src_ff) | cond;
    end
    else
    begin
      nxt_src = cond;
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      src_ff <= EVT_RST;
    end
    else
    begin
      src_ff <= nxt_src;
    end
  end

  assign src_o = src_ff;

endmodule : threshold_source
`default_nettype wire

// ==== tb/pth_cfg_monitor.sv ====
// Purpose: port checks for the threshold interrupt block
// Assumes: top module ports only
// Notes: a shadow of the config word follows bus writes
`timescale 1ns/1ps
`default_nettype none
module pth_cfg_monitor
  import pth_irq_pkg::*;
(
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic [pth_irq_pkg::ADDR_W-1:0] address_i,
  input wire logic read_i,
  input wire logic write_i,
  input wire logic [pth_irq_pkg::BE_W-1:0] byteenable_i,
  input wire logic [pth_irq_pkg::DATA_W-1:0] writedata_i,
  input wire logic waitrequest_o,
  input wire logic pressure_high_i,
  input wire logic pressure_low_i,
  input wire logic baseline_capture_enable_o,
  input wire logic baseline_capture_reset_o,
  input wire logic threshold_irq_o
);
  logic [CFG_W-1:0] sh_ff;
  logic [CFG_W-1:0] nxt_sh;
  logic cw;
  logic sr;
  assign cw = write_i && !waitrequest_o && address_i == CFG_OFFS && byteenable_i[0];
  assign sr = read_i && !waitrequest_o && address_i == SOURCE_OFFS;
  always_comb nxt_sh = cw ? writedata_i[CFG_W-1:0] : sh_ff;
  always_ff @(posedge clk_i or negedge nrst_i)
    if (!nrst_i) sh_ff <= CFG_RST;
    else sh_ff <= nxt_sh;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  wait_one_a: assert property ((read_i || write_i) && waitrequest_o |=> !waitrequest_o ##1 waitrequest_o)
    else $error("waitrequest low not one cycle");
  base_en_a: assert property ($changed(baseline_capture_enable_o) |->
    $past(cw) && baseline_capture_enable_o == $past(writedata_i[BASE_EN_BIT])) else $error("baseline enable");
  base_rst_a: assert property (baseline_capture_reset_o |-> ($past(cw && writedata_i[BASE_RST_BIT]) ||
    $past(cw && writedata_i[BASE_RST_BIT], 2)) ##1 !baseline_capture_reset_o) else $error("baseline reset");
  global_gate_a: assert property (threshold_irq_o |-> sh_ff[GLOBAL_EN_BIT] ||
    $past(sh_ff[GLOBAL_EN_BIT])) else $error("irq without global enable");
  follow_a: assert property ($past(!sh_ff[LATCH_BIT] && !pressure_high_i && !pressure_low_i, 2) &&
    $past(!sh_ff[LATCH_BIT]) |-> !threshold_irq_o) else $error("unlatched irq held");
  low_cause_a: assert property ($rose(threshold_irq_o) && !$past(sh_ff[HIGH_EN_BIT], 2) &&
    $past(sh_ff[GLOBAL_EN_BIT], 2) |-> $past(pressure_low_i && sh_ff[LOW_EN_BIT], 2))
    else $error("low irq without cause");
  high_sup_a: assert property ($rose(threshold_irq_o) && !$past(sh_ff[LOW_EN_BIT], 2) &&
    $past(sh_ff[GLOBAL_EN_BIT], 2) |-> $past(pressure_high_i && sh_ff[HIGH_EN_BIT], 2))
    else $error("high irq not suppressed");
  latch_hold_a: assert property ($fell(threshold_irq_o) && $past(sh_ff[LATCH_BIT], 2) &&
    $past(sh_ff[LATCH_BIT], 3) && sh_ff[GLOBAL_EN_BIT] && $past(sh_ff[GLOBAL_EN_BIT]) |-> $past(sr, 2))
    else $error("latched irq dropped without read");
endmodule : pth_cfg_monitor
bind pressure_threshold_irq_cfg pth_cfg_monitor mon (.clk_i, .nrst_i, .address_i, .read_i, .write_i,
  .byteenable_i, .writedata_i, .waitrequest_o, .pressure_high_i, .pressure_low_i,
  .baseline_capture_enable_o, .baseline_capture_reset_o, .threshold_irq_o);
`default_nettype wire

// ==== tb/pressure_cmp_model.sv ====
// Purpose: pressure compare logic beside the block
// Assumes: pressure and thresholds in counts
// Notes: levels are registered like a sampled compare
`timescale 1ns/1ps
`default_nettype none
module pressure_cmp_model
(
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic [7:0] pressure_i,
  input wire logic [7:0] thr_hi_i,
  input wire logic [7:0] thr_lo_i,
  output logic high_o,
  output logic low_o
);
  always_ff @(posedge clk_i or negedge nrst_i)
    if (!nrst_i)
    begin
      high_o <= 1'b0;
      low_o <= 1'b0;
    end
    else
    begin
      high_o <= pressure_i > thr_hi_i;
      low_o <= pressure_i < thr_lo_i;
    end
endmodule : pressure_cmp_model
`default_nettype wire

// ==== tb/tb_pressure_threshold_irq_cfg.sv ====
// Purpose: register and threshold tests for the block
// Assumes: one bus access at a time
// Notes: settle waits cover the two cycle event latency
`timescale 1ns/1ps
`default_nettype none
module tb_pressure_threshold_irq_cfg;
  import pth_irq_pkg::*;
  logic clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic read_i = 1'b0;
  logic write_i = 1'b0;
  logic [ADDR_W-1:0] address_i = 8'h00;
  logic [BE_W-1:0] byteenable_i = 4'hF;
  logic [DATA_W-1:0] writedata_i = RDATA_ZERO;
  logic [DATA_W-1:0] readdata_o;
  logic [DATA_W-1:0] rd;
  logic waitrequest_o, pressure_high_i, pressure_low_i, irq_o;
  logic baseline_capture_enable_o, baseline_capture_reset_o, threshold_irq_o;
  logic [7:0] pressure = 8'h80;
  int errors = 0;
  int total_checks = 0;
  int pulses = 0;
  always #20 clk_i = ~clk_i;
  always @(posedge clk_i) if (baseline_capture_reset_o === 1'b1) pulses++;
  pressure_cmp_model cmp (.clk_i, .nrst_i, .pressure_i(pressure), .thr_hi_i(8'hC0), .thr_lo_i(8'h40),
    .high_o(pressure_high_i), .low_o(pressure_low_i));
  pressure_threshold_irq_cfg uut (.clk_i, .nrst_i, .address_i, .read_i, .write_i, .byteenable_i,
    .writedata_i, .readdata_o, .waitrequest_o, .pressure_high_i, .pressure_low_i,
    .baseline_capture_enable_o, .baseline_capture_reset_o, .threshold_irq_o, .irq_o);
  task automatic results;
    if (errors == 0 && total_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : results
  task automatic chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic bus(input logic wr, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clk_i);
    address_i <= a;
    writedata_i <= d;
    write_i <= wr;
    read_i <= !wr;
    @(posedge clk_i);
    while (waitrequest_o !== 1'b0) @(posedge clk_i);
    rd = readdata_o;
    write_i <= 1'b0;
    read_i <= 1'b0;
  endtask : bus
  task automatic rchk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
    bus(1'b0, a, RDATA_ZERO);
    chk(rd, e);
  endtask : rchk
  task automatic cfg(input logic [DATA_W-1:0] d, input logic [7:0] p);
    bus(1'b1, CFG_OFFS, d);
    pressure <= p;
    repeat (4) @(posedge clk_i);
  endtask : cfg
  initial
  begin
    repeat (1000) @(posedge clk_i);
    errors++;
    results;
  end
  initial
  begin
    repeat (2) @(posedge clk_i);
    nrst_i <= 1'b1;
    rchk(CFG_OFFS, RDATA_ZERO);
    rchk(8'h3C, RDATA_ZERO);
    cfg(32'h0000_0030, 8'h80);
    chk(baseline_capture_enable_o, 1'b1);
    chk(pulses, 1);
    rchk(CFG_OFFS, 32'h0000_0020);
    cfg(32'h0000_000A, 8'hF0);
    chk(threshold_irq_o, 1'b0);
    rchk(SOURCE_OFFS, RDATA_ZERO);
    cfg(32'h0000_000B, 8'hF0);
    rchk(SOURCE_OFFS, 32'h0000_0005);
    cfg(32'h0000_000B, 8'h20);
    chk(threshold_irq_o, 1'b1);
    rchk(SOURCE_OFFS, 32'h0000_0006);
    cfg(32'h0000_0003, 8'h20);
    chk(threshold_irq_o, 1'b0);
    chk(baseline_capture_enable_o, 1'b0);
    cfg(32'h0000_0009, 8'hF0);
    chk(threshold_irq_o, 1'b1);
    rchk(SOURCE_OFFS, 32'h0000_0005);
    cfg(32'h0000_0009, 8'h80);
    chk(threshold_irq_o, 1'b0);
    cfg(32'h0000_000E, 8'h80);
    cfg(32'h0000_000E, 8'h20);
    cfg(32'h0000_000E, 8'h80);
    chk(threshold_irq_o, 1'b1);
    rchk(SOURCE_OFFS, 32'h0000_0006);
    cfg(32'h0000_000E, 8'h80);
    chk(threshold_irq_o, 1'b0);
    rchk(SOURCE_OFFS, RDATA_ZERO);
    cfg(32'h0000_000A, 8'h20);
    cfg(32'h0000_000A, 8'h80);
    chk(threshold_irq_o, 1'b0);
    rchk(STATUS_OFFS, 32'h0000_0003);
    bus(1'b1, ENABLE_OFFS, 32'h0000_0002);
    repeat (2) @(posedge clk_i);
    chk(irq_o, 1'b1);
    bus(1'b1, CLEAR_OFFS, 32'h0000_0003);
    repeat (2) @(posedge clk_i);
    chk(irq_o, 1'b0);
    bus(1'b1, ENABLE_OFFS, RDATA_ZERO);
    cfg(32'h0000_000A, 8'h20);
    cfg(32'h0000_000A, 8'h80);
    chk(irq_o, 1'b0);
    rchk(STATUS_OFFS, 32'h0000_0002);
    results;
  end
endmodule : tb_pressure_threshold_irq_cfg
`default_nettype wire
